// [common/tgcl_pkg.sv]
// Package: register map, field positions, reset values and states for the traffic test block
`default_nettype none
package tgcl_pkg;
	localparam int unsigned TGCL_ADDR_W = 16;
	localparam int unsigned TGCL_DATA_W = 32;
	// Register byte addresses
	localparam logic [15:0] TGCL_GEN_CTRL_ADDR = 16'h9100;
	localparam logic [15:0] TGCL_PKT_LEN_ADDR = 16'h9104;
	localparam logic [15:0] TGCL_CHK_CTRL_ADDR = 16'h9108;
	localparam logic [15:0] TGCL_CHK_STAT_ADDR = 16'h910c;
	localparam logic [15:0] TGCL_WRAP_ADDR = 16'h9110;
	localparam logic [15:0] TGCL_INT_MASK_ADDR = 16'h9114;
	// Field positions
	localparam int unsigned TGCL_GEN_EN_BIT = 0;
	localparam int unsigned TGCL_CHK_EN_BIT = 0;
	localparam int unsigned TGCL_LPB_EN_BIT = 1;
	localparam int unsigned TGCL_MISMATCH_BIT = 0;
	localparam int unsigned TGCL_LEN_MSB = 15;
	// Reset values
	localparam logic [15:0] TGCL_PKT_LEN_RST = 16'h1000;
	localparam logic [31:0] TGCL_WRAP_RST = 32'h000001ff;
	// Bytes moved per data word
	localparam logic [15:0] TGCL_WORD_BYTES = 16'h0004;
	// Generator states
	typedef enum logic [2:0] {
		TGCL_IDLE = 3'b001,
		TGCL_SEND = 3'b010,
		TGCL_LAST = 3'b100
	} tgcl_gen_state_t;
endpackage : tgcl_pkg
`default_nettype wire

// [common/tgcl_seq_if.sv]
// Interface: sequence counter control and value between top and counter
`timescale 1ns/1ps
`default_nettype none
interface tgcl_seq_if;
	logic restart;
	logic step;
	logic [31:0] limit;
	logic [31:0] value;
	modport owner (output restart, output step, output limit, input value);
	modport counter (input restart, input step, input limit, output value);
endinterface : tgcl_seq_if
`default_nettype wire

// [hw/tgcl_seq_counter.sv]
// Wrapping sequence number counter
`timescale 1ns/1ps
`default_nettype none
module tgcl_seq_counter
	import tgcl_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	tgcl_seq_if.counter seq
);
	logic [31:0] value;
	logic [31:0] base;
	logic at_limit;
	// A restart shows zero at once, so a word taken in that cycle is already in step
	assign base = seq.restart ? 32'h00000000 : value;
	// Wrap back to zero once the limit value has been used
	assign at_limit = (base >= seq.limit);
	assign seq.value = base;

	// A step counts on from the restarted value rather than being lost
	always_ff @(posedge clk) begin
		if (!nrst) begin
			value <= 32'h00000000;
		end else if (seq.step) begin
			value <= at_limit ? 32'h00000000 : base + 32'h00000001;
		end else if (seq.restart) begin
			value <= 32'h00000000;
		end
	end
endmodule : tgcl_seq_counter
`default_nettype wire

// [hw/tgcl_traffic_top.sv]
// Traffic generator, checker and loopback with its register set
`timescale 1ns/1ps
`default_nettype none
module tgcl_traffic_top
	import tgcl_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [15:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	output logic [31:0] card_to_host_channel_zero_data,
	output logic card_to_host_channel_zero_valid,
	output logic card_to_host_channel_zero_last,
	input wire logic card_to_host_channel_zero_ready,
	input wire logic [31:0] host_to_card_channel_zero_data,
	input wire logic host_to_card_channel_zero_valid,
	input wire logic host_to_card_channel_zero_last,
	output logic host_to_card_channel_zero_ready
);
	// Software-visible state
	logic gen_en;
	logic [15:0] pkt_len;
	logic chk_en;
	logic lpb_en;
	logic mismatch;
	logic [31:0] wrap_limit;
	logic int_mask;

	// Address decode
	logic sel_gen, sel_len, sel_chk, sel_stat, sel_wrap, sel_mask;
	assign sel_gen = (reg_addr == TGCL_GEN_CTRL_ADDR);
	assign sel_len = (reg_addr == TGCL_PKT_LEN_ADDR);
	assign sel_chk = (reg_addr == TGCL_CHK_CTRL_ADDR);
	assign sel_stat = (reg_addr == TGCL_CHK_STAT_ADDR);
	assign sel_wrap = (reg_addr == TGCL_WRAP_ADDR);
	assign sel_mask = (reg_addr == TGCL_INT_MASK_ADDR);

	// Register writes
	always_ff @(posedge clk) begin
		if (!nrst) begin
			gen_en <= 1'b0;
			pkt_len <= TGCL_PKT_LEN_RST;
			chk_en <= 1'b0;
			lpb_en <= 1'b0;
			wrap_limit <= TGCL_WRAP_RST;
			int_mask <= 1'b0;
		end else if (reg_wr) begin
			if (sel_gen) gen_en <= reg_wdata[TGCL_GEN_EN_BIT];
			if (sel_len) pkt_len <= reg_wdata[TGCL_LEN_MSB:0];
			if (sel_chk) begin
				chk_en <= reg_wdata[TGCL_CHK_EN_BIT];
				lpb_en <= reg_wdata[TGCL_LPB_EN_BIT];
			end
			if (sel_wrap) wrap_limit <= reg_wdata;
			if (sel_mask) int_mask <= reg_wdata[TGCL_MISMATCH_BIT];
		end
	end

	// Read mux; unmapped addresses read zero
	logic [31:0] rd_mux;
	assign rd_mux = sel_gen ? {31'h0, gen_en} :
		sel_len ? {16'h0000, pkt_len} :
		sel_chk ? {30'h0, lpb_en, chk_en} :
		sel_stat ? {31'h0, mismatch} :
		sel_wrap ? wrap_limit :
		sel_mask ? {31'h0, int_mask} : 32'h00000000;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			reg_rdata <= 32'h00000000;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
		end
	end

	// Generator and checker each keep their own sequence counter
	tgcl_seq_if gen_seq ();
	tgcl_seq_if chk_seq ();

	tgcl_seq_counter u_gen_seq (
		.clk(clk),
		.nrst(nrst),
		.seq(gen_seq)
	);

	tgcl_seq_counter u_chk_seq (
		.clk(clk),
		.nrst(nrst),
		.seq(chk_seq)
	);

	// Enable rising edges restart the sequences
	logic gen_en_q, chk_en_q;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			gen_en_q <= 1'b0;
			chk_en_q <= 1'b0;
		end else begin
			gen_en_q <= gen_en;
			chk_en_q <= chk_en;
		end
	end

	// Loopback takes priority over the generator on the outgoing channel
	logic gen_active;
	assign gen_active = gen_en && !lpb_en;

	// Generator state machine
	tgcl_gen_state_t state, next_state;
	logic [15:0] bytes_left, next_bytes_left;
	logic [15:0] len_eff;
	logic out_fire;
	logic gen_valid;
	logic gen_last;
	// A length below one word is raised to one word, so it sends one word
	assign len_eff = (pkt_len < TGCL_WORD_BYTES) ? TGCL_WORD_BYTES : pkt_len;
	assign gen_valid = (state == TGCL_SEND) || (state == TGCL_LAST);
	assign gen_last = (state == TGCL_LAST);
	assign out_fire = gen_valid && card_to_host_channel_zero_ready && !lpb_en;

	always_comb begin
		next_state = state;
		next_bytes_left = bytes_left;
		case (state)
			TGCL_IDLE: begin
				if (gen_active) begin
					next_bytes_left = len_eff;
					next_state = (len_eff <= TGCL_WORD_BYTES) ? TGCL_LAST : TGCL_SEND;
				end
			end
			TGCL_SEND: begin
				if (out_fire) begin
					next_bytes_left = bytes_left - TGCL_WORD_BYTES;
					if (next_bytes_left <= TGCL_WORD_BYTES) next_state = TGCL_LAST;
				end
			end
			TGCL_LAST: begin
				// A packet in flight always completes before the generator stops
				if (out_fire) next_state = TGCL_IDLE;
			end
			default: next_state = TGCL_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= TGCL_IDLE;
			bytes_left <= 16'h0000;
		end else begin
			state <= next_state;
			bytes_left <= next_bytes_left;
		end
	end

	assign gen_seq.restart = gen_en && !gen_en_q;
	assign gen_seq.step = out_fire;
	assign gen_seq.limit = wrap_limit;

	// Incoming channel: ready follows loopback buffer space, otherwise always ready
	logic in_fire;
	logic out_ready_lpb;
	assign host_to_card_channel_zero_ready = lpb_en ? out_ready_lpb : 1'b1;
	assign in_fire = host_to_card_channel_zero_valid && host_to_card_channel_zero_ready;

	// Loopback holds one word; it is freed when the outgoing side accepts it
	logic lpb_full;
	logic [31:0] lpb_data;
	logic lpb_last;
	assign out_ready_lpb = !lpb_full || card_to_host_channel_zero_ready;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			lpb_full <= 1'b0;
			lpb_data <= 32'h00000000;
			lpb_last <= 1'b0;
		end else if (!lpb_en) begin
			lpb_full <= 1'b0;
		end else if (in_fire) begin
			lpb_full <= 1'b1;
			lpb_data <= host_to_card_channel_zero_data;
			lpb_last <= host_to_card_channel_zero_last;
		end else if (card_to_host_channel_zero_ready) begin
			lpb_full <= 1'b0;
		end
	end

	assign card_to_host_channel_zero_valid = lpb_en ? lpb_full : gen_valid;
	assign card_to_host_channel_zero_last = lpb_en ? lpb_last : gen_last;
	assign card_to_host_channel_zero_data = lpb_en ? lpb_data : gen_seq.value;

	// Checker: each accepted word must equal the expected sequence number
	logic chk_fire;
	logic bad_word;
	assign chk_fire = chk_en && in_fire;
	assign bad_word = chk_fire && (host_to_card_channel_zero_data != chk_seq.value);
	assign chk_seq.restart = chk_en && !chk_en_q;
	assign chk_seq.step = chk_fire;
	assign chk_seq.limit = wrap_limit;

	// Sticky mismatch flag; a new mismatch wins over a clear in the same cycle
	logic stat_clr;
	assign stat_clr = reg_wr && sel_stat && reg_wdata[TGCL_MISMATCH_BIT];
	always_ff @(posedge clk) begin
		if (!nrst) begin
			mismatch <= 1'b0;
		end else if (bad_word) begin
			mismatch <= 1'b1;
		end else if (stat_clr) begin
			mismatch <= 1'b0;
		end
	end

	// Level interrupt while the unmasked flag stands
	assign irq = mismatch && int_mask;
endmodule : tgcl_traffic_top
`default_nettype wire

// [verification/tgcl_chk.sv]
// Checker: readback fields, stream hold and interrupt relations at the top ports
`timescale 1ns/1ps
`default_nettype none
module tgcl_chk
	import tgcl_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [15:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic irq,
	input wire logic [31:0] card_to_host_channel_zero_data,
	input wire logic card_to_host_channel_zero_valid,
	input wire logic card_to_host_channel_zero_ready,
	input wire logic host_to_card_channel_zero_valid,
	input wire logic host_to_card_channel_zero_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Accepted inbound word, status clear and mask write
	wire acc = host_to_card_channel_zero_valid && host_to_card_channel_zero_ready;
	wire clr = reg_wr && reg_addr == TGCL_CHK_STAT_ADDR && reg_wdata[0];
	wire msk = reg_wr && reg_addr == TGCL_INT_MASK_ADDR;
	wire cv = card_to_host_channel_zero_valid;
	AST_C2H_HOLD: assert property (
		cv && !card_to_host_channel_zero_ready |=> cv && $stable(card_to_host_channel_zero_data))
		else $error("outgoing word changed while stalled");
	AST_IRQ_STICKY: assert property (
		irq && !clr && !msk |=> irq) else $error("interrupt dropped without a clear");
	AST_IRQ_CLEAR: assert property (
		clr && !acc && !$past(acc) |=> !irq) else $error("status clear left interrupt set");
	AST_IRQ_CAUSE: assert property (
		$rose(irq) |-> $past(acc) || $past(acc, 2) || $past(msk))
		else $error("interrupt rose without a checked word");
	AST_GEN_FIELD: assert property (
		$past(reg_rd && reg_addr == TGCL_GEN_CTRL_ADDR) |-> reg_rdata[31:1] == '0)
		else $error("generator control reads unused bits");
	AST_LEN_FIELD: assert property (
		$past(reg_rd && reg_addr == TGCL_PKT_LEN_ADDR) |-> reg_rdata[31:16] == '0)
		else $error("length reads beyond its field");
	AST_CTRL_FIELD: assert property (
		$past(reg_rd && reg_addr == TGCL_CHK_CTRL_ADDR) |-> reg_rdata[31:2] == '0)
		else $error("checker control reads unused bits");
	AST_STAT_FIELD: assert property (
		$past(reg_rd && reg_addr == TGCL_CHK_STAT_ADDR) |-> reg_rdata[31:1] == '0)
		else $error("status reads unused bits");
endmodule : tgcl_chk
bind tgcl_traffic_top tgcl_chk i_chk(.*);
`default_nettype wire

// [verification/tgcl_dma_model.sv]
// DMA streaming channel model: stalling sink and word source
`timescale 1ns/1ps
`default_nettype none
module tgcl_dma_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic send,
	input wire logic [1:0] stall,
	input wire logic [31:0] bad,
	input wire logic h2c_ready,
	output logic c2h_ready = 1'b0,
	output logic [31:0] h2c_data = 32'h0,
	output logic h2c_valid = 1'b0
);
	logic [31:0] n = 32'h0;
	// Count modulo six matches a wrap of five; word number bad is corrupted
	always @(posedge clk) begin
		c2h_ready <= !stall[0];
		if (!nrst) begin
			n <= 32'h0;
			h2c_valid <= 1'b0;
		end else if (h2c_valid && h2c_ready) begin
			n <= n + 32'h1;
			h2c_valid <= 1'b0;
			h2c_data <= ~h2c_data; // Released data must not repeat the word
		end else if (!h2c_valid && !send) begin
			n <= 32'h0;
		end else if (!h2c_valid && !stall[1]) begin
			h2c_valid <= 1'b1;
			h2c_data <= (n % 32'h6) ^ {31'h0, n == bad};
		end
	end
endmodule : tgcl_dma_model
`default_nettype wire

// [verification/tb.sv]
// Testbench: registers, generator, checker and loopback against a bench model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
	import tgcl_pkg::*;
	logic clk = 0, nrst = 0, wr = 0, rd = 0, send = 0, irq, cv, cl, cr, hv, hr;
	logic [15:0] addr = 16'h0;
	logic [31:0] wd = 32'h0, rdat, cd, hd, tmp, le, bad = 32'h0, rs = 32'd10413, q[$];
	logic [1:0] stall = 2'h0;
	logic ll, lq[$];
	logic [31:0] rv[7] = '{32'h0, 32'h1000, 32'h0, 32'h0, 32'h1ff, 32'h0, 32'h0};
	int miscompares, compares, cyc, mode, gs, wc, nw, hc, ln[2] = '{12, 2}, bd[2] = '{100, 3};
	function logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xs
	tgcl_traffic_top i_dut(.clk(clk), .nrst(nrst), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
		.reg_rd(rd), .reg_rdata(rdat), .irq(irq), .card_to_host_channel_zero_data(cd),
		.card_to_host_channel_zero_valid(cv), .card_to_host_channel_zero_last(cl),
		.card_to_host_channel_zero_ready(cr), .host_to_card_channel_zero_data(hd),
		.host_to_card_channel_zero_valid(hv), .host_to_card_channel_zero_last(hd[31]),
		.host_to_card_channel_zero_ready(hr));
	tgcl_dma_model i_dma(.clk(clk), .nrst(nrst), .send(send), .stall(stall), .bad(bad),
		.h2c_ready(hr), .c2h_ready(cr), .h2c_data(hd), .h2c_valid(hv));
	initial forever #5 clk = ~clk;
	task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rdc(input logic [15:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK("reg read", e, rdat)
	endtask : rdc
	task print_verdict();
		if (miscompares == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : print_verdict
	// Random stalls, hang limit, and the outgoing word scoreboard
	always @(posedge clk) begin
		stall <= 2'(xs());
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			print_verdict();
		end
		if (hv && hr) hc++;
		if (hv && hr && mode == 2) begin
			q.push_back(hd);
			lq.push_back(hd[31]);
		end
		if (cv && cr && mode == 1) begin
			`CHK("gen data", gs[31:0], cd)
			`CHK("gen last", wc == nw - 1, cl)
			gs = (gs == 5) ? 0 : gs + 1;
			wc = (wc == nw - 1) ? 0 : wc + 1;
		end
		if (cv && cr && mode == 2) begin
			le = q.pop_front();
			`CHK("loop data", le, cd)
			ll = lq.pop_front();
			`CHK("loop last", ll, cl)
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		// Reset values, mask, then an unmapped word that reads zero
		for (int i = 0; i < 7; i++) rdc(16'h9100 + 16'(4 * i), rv[i]);
		tmp = {16'h0, 16'(xs())};
		wr_reg(TGCL_PKT_LEN_ADDR, tmp);
		rdc(TGCL_PKT_LEN_ADDR, tmp);
		wr_reg(TGCL_WRAP_ADDR, 32'h5);
		mode = 1;
		// Three-word packets, then a length below one word
		foreach (ln[k]) begin
			nw = ln[k] / 4 > 0 ? ln[k] / 4 : 1;
			gs = 0;
			wc = 0;
			wr_reg(TGCL_PKT_LEN_ADDR, 32'(ln[k]));
			wr_reg(TGCL_GEN_CTRL_ADDR, 32'h1);
			repeat (60) @(posedge clk);
			wr_reg(TGCL_GEN_CTRL_ADDR, 32'h0);
			repeat (30) @(posedge clk);
			#1 `CHK("gen idle", 1'b0, cv)
		end
		mode = 0;
		// Clean stream across the wrap, then one corrupted word
		foreach (bd[k]) begin
			bad = bd[k];
			hc = 0;
			wr_reg(TGCL_CHK_CTRL_ADDR, 32'h1);
			send <= 1'b1;
			while (hc < 9) @(posedge clk);
			send <= 1'b0;
			wr_reg(TGCL_CHK_CTRL_ADDR, 32'h0);
			rdc(TGCL_CHK_STAT_ADDR, 32'(bd[k] < 9));
		end
		wr_reg(TGCL_CHK_STAT_ADDR, 32'h0);
		rdc(TGCL_CHK_STAT_ADDR, 32'h1);
		`CHK("irq masked", 1'b0, irq)
		wr_reg(TGCL_INT_MASK_ADDR, 32'h1);
		#1 `CHK("irq raised", 1'b1, irq)
		wr_reg(TGCL_CHK_STAT_ADDR, 32'h1);
		#1 `CHK("irq cleared", 1'b0, irq)
		// Loopback under stalls with the checker off
		mode = 2;
		bad = 32'h0;
		hc = 0;
		wr_reg(TGCL_CHK_CTRL_ADDR, 32'h2);
		send <= 1'b1;
		while (hc < 12) @(posedge clk);
		send <= 1'b0;
		repeat (20) @(posedge clk);
		`CHK("loop drained", 0, q.size())
		rdc(TGCL_CHK_STAT_ADDR, 32'h0);
		print_verdict();
	end
endmodule : tb
`default_nettype wire
